// File: hdl/stc_pkg.sv
// Notes on behaviour
// - Sync, clock select 1: drive serial clock.
// - Sync, clock select 0: peer supplies clock.
// - Async mode ignores clock select bit.
// - Width bit picks 9 or 8 bits.
// - Mode bit: 1 synchronous, 0 asynchronous.
// - Async speed bit picks baud; sync ignores.
// - Read-only idle flag, 1 when idle.
package stc_pkg;

  // Register offsets
  localparam logic [2:0] ADDR_CTRL  = 3'h0;
  localparam logic [2:0] ADDR_DATA  = 3'h1;
  localparam logic [2:0] ADDR_RXEN  = 3'h2;
  localparam logic [2:0] ADDR_BAUD  = 3'h3;
  localparam logic [2:0] ADDR_ISTAT = 3'h4;
  localparam logic [2:0] ADDR_IMASK = 3'h5;

  // Widths and reset values
  localparam int         BAUD_W     = 8;
  localparam int         LIM_W      = 12;
  localparam logic [7:0] CTRL_RST   = 8'h02;
  localparam logic [7:0] BAUD_RST   = 8'h00;

  // Receive enable field positions
  localparam int RX_SINGLE = 0;
  localparam int RX_CONT   = 1;

  // Interrupt status bit positions
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_DROP  = 1;

  // Frame lengths in bits
  localparam logic [3:0] BITS_ASYNC8 = 4'ha;
  localparam logic [3:0] BITS_ASYNC9 = 4'hb;
  localparam logic [3:0] BITS_SYNC8  = 4'h8;
  localparam logic [3:0] BITS_SYNC9  = 4'h9;

  // Control register layout, bit 7 first
  typedef struct packed {
    logic clock_source_select;
    logic tx_nine_bit_enable;
    logic tx_enable_bit;
    logic sync_mode;
    logic unused;
    logic high_speed_baud_select;
    logic tx_idle_flag;
    logic tx_ninth_data_bit;
  } stc_ctrl_t;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } stc_bus_t;

endpackage : stc_pkg

// File: hdl/stc_top.sv
`timescale 1ns/1ps
module stc_top (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            nrst,
  // Register port
  input  wire stc_pkg::stc_bus_t bus,
  output logic [7:0]           rd_data_r,
  // Serial pins
  output logic                 tx_line_r,
  output logic                 data_oe_n_r,
  output logic                 sclk_out_r,
  output logic                 sclk_oe_n_r,
  input  wire logic            sclk_in,
  // Interrupt
  output logic                 irq_r
);

  typedef enum logic {ST_IDLE, ST_SHIFT} stc_state_t;

  stc_pkg::stc_ctrl_t          ctrl_r, ctrl_nxt;
  logic [1:0]                  rxen_r, rxen_nxt;
  logic [stc_pkg::BAUD_W-1:0]  baud_r, baud_nxt;
  logic [1:0]                  istat_r, istat_nxt;
  logic [1:0]                  imask_r, imask_nxt;
  logic [7:0]                  buf_r, buf_nxt;
  logic                        buf_v_r, buf_v_nxt;
  logic [7:0]                  rd_data_nxt;
  logic                        irq_nxt;
  stc_state_t                  state_r, state_nxt;
  logic [10:0]                 sh_r, sh_nxt;
  logic [3:0]                  cnt_r, cnt_nxt;
  logic [stc_pkg::LIM_W-1:0]   bcnt_r, bcnt_nxt;
  logic [stc_pkg::LIM_W-1:0]   lim_w;
  logic                        tx_line_nxt, sclk_out_nxt;
  logic                        sclk_oe_n_nxt, data_oe_n_nxt;
  logic                        s1_r, s2_r, s3_r;
  logic                        sync_w, master_w, run_w, tick_w;
  logic                        step_w, load_w, done_w;
  logic                        wr_data_w;
  logic [1:0]                  ev_w;

  // Mode decode
  assign sync_w    = ctrl_r.sync_mode;
  assign master_w  = sync_w & ctrl_r.clock_source_select;
  // Receive in sync mode owns the data line
  assign run_w     = ctrl_r.tx_enable_bit & ~(sync_w & (rxen_r[stc_pkg::RX_SINGLE] | rxen_r[stc_pkg::RX_CONT]));
  assign wr_data_w = bus.wr && (bus.addr == stc_pkg::ADDR_DATA);

  // Baud reload: the speed bit only matters in async mode
  always_comb begin
    if (sync_w) begin
      lim_w = {4'h0, baud_r};
    end else if (ctrl_r.high_speed_baud_select) begin
      lim_w = {2'h0, baud_r, 2'h3};
    end else begin
      lim_w = {baud_r, 4'hf};
    end
  end

  assign tick_w = (bcnt_r == '0);

  // Bit step source per mode
  always_comb begin
    if (!sync_w) begin
      step_w = tick_w;
    end else if (master_w) begin
      step_w = tick_w & sclk_out_r;
    end else begin
      step_w = s3_r & ~s2_r;
    end
  end

  assign load_w = (state_r == ST_IDLE) && run_w && buf_v_r;
  assign done_w = (state_r == ST_SHIFT) && run_w && step_w && (cnt_r == 4'h0);
  assign ev_w   = {wr_data_w & buf_v_r, done_w};

  // Register file next values
  always_comb begin
    ctrl_nxt  = ctrl_r;
    rxen_nxt  = rxen_r;
    baud_nxt  = baud_r;
    imask_nxt = imask_r;
    buf_nxt   = buf_r;
    buf_v_nxt = buf_v_r;
    istat_nxt = istat_r;
    if (bus.wr) begin
      unique case (bus.addr)
        stc_pkg::ADDR_CTRL: begin
          ctrl_nxt              = bus.wdata;
          ctrl_nxt.unused       = 1'b0;
          ctrl_nxt.tx_idle_flag = 1'b0;
        end
        stc_pkg::ADDR_RXEN:  rxen_nxt  = bus.wdata[1:0];
        stc_pkg::ADDR_BAUD:  baud_nxt  = bus.wdata;
        stc_pkg::ADDR_ISTAT: istat_nxt = istat_r & ~bus.wdata[1:0];
        stc_pkg::ADDR_IMASK: imask_nxt = bus.wdata[1:0];
        default: ;
      endcase
    end
    // A second write while one is pending is dropped
    if (wr_data_w && !buf_v_r) begin
      buf_nxt   = bus.wdata;
      buf_v_nxt = 1'b1;
    end
    if (load_w) begin
      buf_v_nxt = 1'b0;
    end
    // Set wins over a same-cycle clear
    istat_nxt = istat_nxt | ev_w;
    irq_nxt   = |(istat_nxt & imask_nxt);
  end

  // Read mux, data stands one cycle only
  always_comb begin
    rd_data_nxt = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        stc_pkg::ADDR_CTRL: begin
          rd_data_nxt    = ctrl_r;
          rd_data_nxt[1] = (state_r == ST_IDLE);
        end
        stc_pkg::ADDR_DATA:  rd_data_nxt = buf_r;
        stc_pkg::ADDR_RXEN:  rd_data_nxt = {6'h00, rxen_r};
        stc_pkg::ADDR_BAUD:  rd_data_nxt = baud_r;
        stc_pkg::ADDR_ISTAT: rd_data_nxt = {6'h00, istat_r};
        stc_pkg::ADDR_IMASK: rd_data_nxt = {6'h00, imask_r};
        default:             rd_data_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r    <= stc_pkg::CTRL_RST;
      rxen_r    <= 2'h0;
      baud_r    <= stc_pkg::BAUD_RST;
      istat_r   <= 2'h0;
      imask_r   <= 2'h0;
      buf_r     <= 8'h00;
      buf_v_r   <= 1'b0;
      rd_data_r <= 8'h00;
      irq_r     <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      rxen_r    <= rxen_nxt;
      baud_r    <= baud_nxt;
      istat_r   <= istat_nxt;
      imask_r   <= imask_nxt;
      buf_r     <= buf_nxt;
      buf_v_r   <= buf_v_nxt;
      rd_data_r <= rd_data_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // Transmit engine next values
  always_comb begin
    state_nxt     = state_r;
    sh_nxt        = sh_r;
    cnt_nxt       = cnt_r;
    tx_line_nxt   = tx_line_r;
    sclk_out_nxt  = sclk_out_r;
    bcnt_nxt      = tick_w ? lim_w : bcnt_r - 1'b1;
    sclk_oe_n_nxt = ~master_w;
    data_oe_n_nxt = sync_w ? (state_r == ST_IDLE) : ~ctrl_r.tx_enable_bit;
    if (!run_w) begin
      // Disable aborts any frame in flight
      state_nxt    = ST_IDLE;
      sclk_out_nxt = 1'b0;
      if (!sync_w) begin
        tx_line_nxt = 1'b1;
      end
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          sclk_out_nxt = 1'b0;
          if (!sync_w) begin
            tx_line_nxt = 1'b1;
          end
          if (load_w) begin
            state_nxt = ST_SHIFT;
            bcnt_nxt  = lim_w;
            if (sync_w) begin
              sh_nxt  = {2'b00, ctrl_r.tx_ninth_data_bit, buf_r};
              cnt_nxt = ctrl_r.tx_nine_bit_enable ? stc_pkg::BITS_SYNC9 : stc_pkg::BITS_SYNC8;
            end else begin
              sh_nxt  = {1'b1, ctrl_r.tx_ninth_data_bit | ~ctrl_r.tx_nine_bit_enable, buf_r, 1'b0};
              cnt_nxt = ctrl_r.tx_nine_bit_enable ? stc_pkg::BITS_ASYNC9 : stc_pkg::BITS_ASYNC8;
            end
          end
        end
        ST_SHIFT: begin
          if (master_w && tick_w) begin
            sclk_out_nxt = ~sclk_out_r;
          end
          if (step_w) begin
            if (cnt_r == 4'h0) begin
              state_nxt = ST_IDLE;
            end else begin
              tx_line_nxt = sh_r[0];
              sh_nxt      = {1'b1, sh_r[10:1]};
              cnt_nxt     = cnt_r - 1'b1;
            end
          end
        end
      endcase
    end
    if (!master_w) begin
      sclk_out_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r     <= ST_IDLE;
      sh_r        <= 11'h7ff;
      cnt_r       <= 4'h0;
      bcnt_r      <= '0;
      tx_line_r   <= 1'b1;
      sclk_out_r  <= 1'b0;
      sclk_oe_n_r <= 1'b1;
      data_oe_n_r <= 1'b1;
    end else begin
      state_r     <= state_nxt;
      sh_r        <= sh_nxt;
      cnt_r       <= cnt_nxt;
      bcnt_r      <= bcnt_nxt;
      tx_line_r   <= tx_line_nxt;
      sclk_out_r  <= sclk_out_nxt;
      sclk_oe_n_r <= sclk_oe_n_nxt;
      data_oe_n_r <= data_oe_n_nxt;
    end
  end

  // Peer clock synchroniser; s3 only feeds the edge detect
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= sclk_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_load;
    load_w;
  endsequence

  a_master_clk_drive: assert property (master_w |=> !sclk_oe_n_r)
    else $error("master does not drive serial clock");
  a_slave_clk_free: assert property (sync_w && !ctrl_r.clock_source_select |=> sclk_oe_n_r && !sclk_out_r)
    else $error("slave drives serial clock");
  a_async_clk_ignore: assert property (!sync_w |=> sclk_oe_n_r && !sclk_out_r)
    else $error("async mode reacts to clock select");
  a_nine_bit_len: assert property (s_load ##0 (ctrl_r.tx_nine_bit_enable && !sync_w) |=> cnt_r == 4'hb)
    else $error("async nine-bit frame length wrong");
  a_sync_eight_len: assert property (s_load ##0 (!ctrl_r.tx_nine_bit_enable && sync_w) |=> cnt_r == 4'h8)
    else $error("sync eight-bit frame length wrong");
  a_async_start_bit: assert property (s_load ##0 !sync_w |=> sh_r[0] == 1'b0)
    else $error("async frame lacks start bit");
  a_high_speed_lim: assert property (tick_w && !sync_w && ctrl_r.high_speed_baud_select
                                     |=> bcnt_r == {2'h0, $past(baud_r), 2'h3})
    else $error("high speed reload wrong");
  a_sync_speed_ign: assert property (tick_w && sync_w |=> bcnt_r == {4'h0, $past(baud_r)})
    else $error("sync mode uses speed bit");
  a_idle_flag_read: assert property (bus.rd && bus.addr == stc_pkg::ADDR_CTRL
                                     |=> rd_data_r[1] == ($past(state_r) == ST_IDLE))
    else $error("idle flag disagrees with engine");
  a_run_gate_idle: assert property (!run_w |=> state_r == ST_IDLE)
    else $error("transmitter runs while gated");
  // Remaining width and speed corners, so each decode arm is watched
  a_async_eight_len: assert property (s_load ##0 (!ctrl_r.tx_nine_bit_enable && !sync_w) |=> cnt_r == 4'ha)
    else $error("async eight-bit frame length wrong");
  a_sync_nine_len: assert property (s_load ##0 (ctrl_r.tx_nine_bit_enable && sync_w) |=> cnt_r == 4'h9)
    else $error("sync nine-bit frame length wrong");
  a_low_speed_lim: assert property (tick_w && !sync_w && !ctrl_r.high_speed_baud_select
                                    |=> bcnt_r == {$past(baud_r), 4'hf})
    else $error("low speed reload wrong");
  // Data may only move as the master clock falls
  a_master_fall_step: assert property (master_w && step_w |=> !sclk_out_r)
    else $error("master data moves off the falling clock");

endmodule : stc_top

// File: verif/stc_peer.sv
`timescale 1ns/1ps
module stc_peer (
  // Clock
  input  wire logic       ref_clk,
  // Bench control
  input  wire logic       run,
  input  wire logic [3:0] half,
  // Serial clock to the device
  output logic            sclk
);
  logic [3:0] cnt_r;

  // Clock stands high between frames, so a stalled peer really stalls the slave
  always_ff @(posedge ref_clk) begin
    if (!run) begin
      cnt_r <= 4'h0;
      sclk  <= 1'b1;
    end else if (cnt_r == half) begin
      cnt_r <= 4'h0;
      sclk  <= ~sclk;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule : stc_peer

// File: verif/stc_top_test.sv
`timescale 1ns/1ps
module stc_top_test;
  logic              ref_clk = 1'b0;
  logic              nrst = 1'b0;
  stc_pkg::stc_bus_t bus = '0;
  logic [7:0]        rd_data_r;
  logic              tx_line_r, data_oe_n_r, sclk_out_r, sclk_oe_n_r, irq_r, sclk, v;
  logic              peer_run = 1'b0;
  logic              rd_d = 1'b0;
  logic [7:0]        exp_q[$];
  logic [31:0]       seed = 32'ha58d;
  logic [7:0]        ctrl;
  logic [8:0]        got;
  logic [7:0]        cap = 8'h00;
  int                n_fail = 0;
  int                num_checks = 0;
  int                cyc = 0;
  int                per;

  always #4 ref_clk = ~ref_clk;

  stc_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .bus(bus), .rd_data_r(rd_data_r), .tx_line_r(tx_line_r),
    .data_oe_n_r(data_oe_n_r), .sclk_out_r(sclk_out_r), .sclk_oe_n_r(sclk_oe_n_r), .sclk_in(sclk), .irq_r(irq_r));
  stc_peer peer_u (.ref_clk(ref_clk), .run(peer_run), .half(4'h7), .sclk(sclk));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    num_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // One-cycle strobes, launched just after a rising edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    exp_q.push_back(e);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus <= '0;
  endtask : rd

  // Read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    rd_d <= bus.rd;
    if (rd_d) begin
      check({1'b0, rd_data_r}, {1'b0, exp_q.pop_front()});
    end
  end

  // Peer-side capture on each rising serial clock; only the last eight count
  always @(posedge sclk or posedge sclk_out_r) begin
    cap <= {tx_line_r, cap[7:1]};
  end

  // Hang guard, well above the longest expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      stop_test();
    end
  end

  // Samples an async frame at bit centres
  task automatic rx_async(input int nb, output logic [8:0] r);
    int i;
    r = '0;
    i = 0;
    while (tx_line_r !== 1'b0 && i < 2000) begin
      @(negedge ref_clk);
      i++;
    end
    repeat (per / 2) @(negedge ref_clk);
    check({8'h00, tx_line_r}, 9'h000);
    for (i = 0; i < nb; i++) begin
      repeat (per) @(negedge ref_clk);
      r[i] = tx_line_r;
    end
    repeat (per) @(negedge ref_clk);
    check({8'h00, tx_line_r}, 9'h001);
  endtask : rx_async

  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(stc_pkg::ADDR_CTRL, stc_pkg::CTRL_RST);
    rd(3'h7, 8'h00);
    wr(stc_pkg::ADDR_IMASK, 8'h01);
    // Async frames over both speeds, widths and clock-select values
    for (int m = 0; m < 4; m++) begin
      seed = lfsr(seed);
      ctrl = {m[0], m[1], 1'b1, 2'b00, m[0], 1'b0, seed[8]};
      per = m[0] ? 4 * (m[1] + 1) : 16 * (m[1] + 1);
      wr(stc_pkg::ADDR_BAUD, {7'h00, m[1]});
      wr(stc_pkg::ADDR_CTRL, ctrl);
      wr(stc_pkg::ADDR_DATA, seed[7:0]);
      fork
        rd(stc_pkg::ADDR_CTRL, ctrl);
        rx_async(8 + m[1], got);
      join
      check(got, m[1] ? {seed[8], seed[7:0]} : {1'b0, seed[7:0]});
      check({7'h00, sclk_oe_n_r, sclk_out_r}, 9'h002);
      repeat (2 * per) @(posedge ref_clk);
      rd(stc_pkg::ADDR_ISTAT, 8'h01);
      check({8'h00, irq_r}, 9'h001);
      wr(stc_pkg::ADDR_ISTAT, 8'h01);
      @(negedge ref_clk);
      check({8'h00, irq_r}, 9'h000);
      rd(stc_pkg::ADDR_CTRL, ctrl | 8'h02);
    end
    // Sync slave waits for the peer clock
    wr(stc_pkg::ADDR_CTRL, 8'h30);
    wr(stc_pkg::ADDR_DATA, seed[15:8]);
    repeat (40) @(posedge ref_clk);
    rd(stc_pkg::ADDR_CTRL, 8'h30);
    check({8'h00, sclk_oe_n_r}, 9'h001);
    peer_run <= 1'b1;
    // Eighth rising peer clock has sampled the last bit, ninth not yet come
    repeat (136) @(posedge ref_clk);
    check({1'b0, cap}, {1'b0, seed[15:8]});
    repeat (164) @(posedge ref_clk);
    peer_run <= 1'b0;
    rd(stc_pkg::ADDR_CTRL, 8'h32);
    // Sync master drives its own clock
    wr(stc_pkg::ADDR_BAUD, 8'h01);
    wr(stc_pkg::ADDR_CTRL, 8'hb0);
    wr(stc_pkg::ADDR_DATA, seed[23:16]);
    repeat (6) @(negedge ref_clk);
    check({8'h00, sclk_oe_n_r}, 9'h000);
    v = sclk_out_r;
    repeat (2) @(negedge ref_clk);
    check({8'h00, sclk_out_r}, {8'h00, ~v});
    repeat (100) @(posedge ref_clk);
    check({1'b0, cap}, {1'b0, seed[23:16]});
    rd(stc_pkg::ADDR_CTRL, 8'hb2);
    // Receive enable holds the transmitter off; clearing run aborts
    wr(stc_pkg::ADDR_RXEN, 8'h02);
    wr(stc_pkg::ADDR_DATA, seed[31:24]);
    repeat (60) @(posedge ref_clk);
    rd(stc_pkg::ADDR_CTRL, 8'hb2);
    check({8'h00, data_oe_n_r}, 9'h001);
    wr(stc_pkg::ADDR_RXEN, 8'h00);
    rd(stc_pkg::ADDR_CTRL, 8'hb0);
    wr(stc_pkg::ADDR_CTRL, 8'h90);
    rd(stc_pkg::ADDR_CTRL, 8'h92);
    repeat (4) @(posedge ref_clk);
    stop_test();
  end
endmodule : stc_top_test
